// ### src/pwm_auto_shutdown_deadband.sv
/*
 * PWM output protection: trip source selection, shutdown pin states,
 * shutdown event flag, restart on period boundary, dead-band delay and
 * an event interrupt, behind a plain register port.
 * Assumes a PWM core on the same clock that supplies raw output levels,
 * a period-start pulse and a half-bridge mode level; comparator and pin
 * inputs arrive asynchronously.
 */
// Strobed register access and the register offsets are this design's own decisions.
// Operation
// - event flag shows outputs held in shutdown
// - source code 000 disables, 001-011 select comparator trips
// - codes 100-111 add low interrupt pin
// - pins a and c low, high, float
// - pins b and d low, high, float
// - trip is level, shutdown holds while present
// - flag writes ignored while trip present
// - restart only at next period start
// - dead-band delays only inactive-to-active edges
// - seven-bit dead-band count in instruction cycles
`timescale 1ns/1ps

module pwm_auto_shutdown_deadband #(
    parameter int DEADBAND_BITS = 7
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // pwm core side
    input wire logic pwm_a_in,
    input wire logic pwm_b_in,
    input wire logic pwm_c_in,
    input wire logic pwm_d_in,
    input wire logic period_start_in,
    input wire logic half_bridge_in,
    input wire logic instr_tick_in,
    // trip sources
    input wire logic comparator_one_in,
    input wire logic comparator_two_in,
    input wire logic ext_int_pin_in,
    input wire logic comparator_two_sync_enable_in,
    input wire logic timer_one_sync_in,
    // output pins
    output logic pwm_output_a_out,
    output logic pwm_output_a_oe_out,
    output logic pwm_output_b_out,
    output logic pwm_output_b_oe_out,
    output logic pwm_output_c_out,
    output logic pwm_output_c_oe_out,
    output logic pwm_output_d_out,
    output logic pwm_output_d_oe_out,
    // interrupt
    output logic irq_out
);

    initial begin
        if (DEADBAND_BITS != pwm_shutdown_pkg::DEADBAND_WIDTH) begin
            $error("pwm_auto_shutdown_deadband: DEADBAND_BITS must be 7");
        end
    end

    // ----------------
    // declarations
    // ----------------
    logic [7:0] shutdown_control_q;
    logic [7:0] deadband_control_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic [2:0] cmp1_sync_q;
    logic [2:0] cmp2_sync_q;
    logic [2:0] pin_sync_q;
    logic cmp2_held_q;
    logic cmp2_eff;
    logic trip_now;
    logic trip_q;
    logic flag_q;
    logic run_q;
    logic restart_pulse;
    logic [3:0] raw;
    logic [3:0] shaped;
    logic [3:0] pin_level_q;
    logic [3:0] pin_oe_q;
    logic [2:0] src_sel;
    logic [1:0] ac_state;
    logic [1:0] bd_state;
    logic flag_write_clear;

    assign src_sel = shutdown_control_q[pwm_shutdown_pkg::SOURCE_MSB:pwm_shutdown_pkg::SOURCE_LSB];
    assign ac_state = shutdown_control_q[pwm_shutdown_pkg::AC_STATE_MSB:pwm_shutdown_pkg::AC_STATE_LSB];
    assign bd_state = shutdown_control_q[pwm_shutdown_pkg::BD_STATE_MSB:pwm_shutdown_pkg::BD_STATE_LSB];

    // ----------------
    // input synchronisers
    // ----------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            cmp1_sync_q <= 3'h0;
            cmp2_sync_q <= 3'h0;
            pin_sync_q <= 3'h7;
        end else if (clk_en_in) begin
            cmp1_sync_q <= {cmp1_sync_q[1:0], comparator_one_in};
            cmp2_sync_q <= {cmp2_sync_q[1:0], comparator_two_in};
            pin_sync_q <= {pin_sync_q[1:0], ext_int_pin_in};
        end
    end

    // ----------------
    // comparator two timer synchronisation
    // ----------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            cmp2_held_q <= 1'b0;
        end else if (clk_en_in && timer_one_sync_in) begin
            cmp2_held_q <= cmp2_sync_q[2];
        end
    end

    assign cmp2_eff = comparator_two_sync_enable_in ? cmp2_held_q : cmp2_sync_q[2];

    // ----------------
    // trip source selection
    // ----------------
    always_comb begin
        unique case (src_sel)
            pwm_shutdown_pkg::SRC_DISABLED: trip_now = 1'b0;
            pwm_shutdown_pkg::SRC_CMP_ONE: trip_now = cmp1_sync_q[2];
            pwm_shutdown_pkg::SRC_CMP_TWO: trip_now = cmp2_eff;
            pwm_shutdown_pkg::SRC_CMP_EITHER: trip_now = cmp1_sync_q[2] | cmp2_eff;
            pwm_shutdown_pkg::SRC_PIN: trip_now = !pin_sync_q[2];
            pwm_shutdown_pkg::SRC_PIN_CMP_ONE: trip_now = !pin_sync_q[2] | cmp1_sync_q[2];
            pwm_shutdown_pkg::SRC_PIN_CMP_TWO: trip_now = !pin_sync_q[2] | cmp2_eff;
            pwm_shutdown_pkg::SRC_PIN_CMP_EITHER: trip_now = !pin_sync_q[2] | cmp1_sync_q[2] | cmp2_eff;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            trip_q <= 1'b0;
        end else if (clk_en_in) begin
            trip_q <= trip_now;
        end
    end

    // ----------------
    // shutdown event flag
    // ----------------
    assign flag_write_clear = reg_write_in && reg_addr_in == pwm_shutdown_pkg::ADDR_SHUTDOWN_CONTROL
        && !reg_wdata_in[pwm_shutdown_pkg::EVENT_FLAG_BIT];

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            flag_q <= pwm_shutdown_pkg::SHUTDOWN_CONTROL_RESET[pwm_shutdown_pkg::EVENT_FLAG_BIT];
        end else if (clk_en_in) begin
            if (trip_now) begin
                flag_q <= 1'b1;
            end else if (flag_write_clear) begin
                flag_q <= 1'b0;
            end else if (deadband_control_q[pwm_shutdown_pkg::AUTO_RESTART_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ----------------
    // run state, resumes on period start
    // ----------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            run_q <= 1'b1;
        end else if (clk_en_in) begin
            if (flag_q || trip_now) begin
                run_q <= 1'b0;
            end else if (!run_q && period_start_in) begin
                run_q <= 1'b1;
            end
        end
    end

    assign restart_pulse = !run_q && !flag_q && !trip_now && period_start_in;

    // ----------------
    // registers
    // ----------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            shutdown_control_q <= pwm_shutdown_pkg::SHUTDOWN_CONTROL_RESET;
            deadband_control_q <= pwm_shutdown_pkg::DEADBAND_CONTROL_RESET;
            irq_mask_q <= pwm_shutdown_pkg::IRQ_RESET;
        end else if (clk_en_in && reg_write_in) begin
            unique case (reg_addr_in)
                pwm_shutdown_pkg::ADDR_SHUTDOWN_CONTROL: shutdown_control_q <= reg_wdata_in;
                pwm_shutdown_pkg::ADDR_DEADBAND_CONTROL: deadband_control_q <= reg_wdata_in;
                pwm_shutdown_pkg::ADDR_IRQ_MASK: irq_mask_q <= reg_wdata_in[1:0];
                pwm_shutdown_pkg::ADDR_IRQ_STATUS: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            irq_status_q <= pwm_shutdown_pkg::IRQ_RESET;
        end else if (clk_en_in) begin
            irq_status_q <= (irq_status_q
                & ~((reg_write_in && reg_addr_in == pwm_shutdown_pkg::ADDR_IRQ_STATUS) ? reg_wdata_in[1:0] : 2'h0))
                | {restart_pulse, trip_now && !trip_q};
        end
    end

    assign irq_out = |(irq_status_q & irq_mask_q);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata_q <= 8'h00;
        end else if (clk_en_in) begin
            rdata_q <= 8'h00;
            if (reg_read_in) begin
                unique case (reg_addr_in)
                    pwm_shutdown_pkg::ADDR_SHUTDOWN_CONTROL: rdata_q <= {flag_q, shutdown_control_q[6:0]};
                    pwm_shutdown_pkg::ADDR_DEADBAND_CONTROL: rdata_q <= deadband_control_q;
                    pwm_shutdown_pkg::ADDR_IRQ_STATUS: rdata_q <= {6'h00, irq_status_q};
                    pwm_shutdown_pkg::ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
                endcase
            end
        end
    end

    assign reg_rdata_out = rdata_q;

    // ------------------------------------------------------------
    // dead-band on each channel in half-bridge mode
    // ------------------------------------------------------------
    assign raw = {pwm_d_in, pwm_c_in, pwm_b_in, pwm_a_in};

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_deadband
            logic delayed;
            deadband_delay #(
                .WIDTH(DEADBAND_BITS)
            ) u_delay (
                .sys_clk_in(sys_clk_in),
                .resetn_in(resetn_in),
                .clk_en_in(clk_en_in),
                .tick_in(instr_tick_in),
                .delay_in(deadband_control_q[DEADBAND_BITS-1:0]),
                .level_in(raw[ch]),
                .level_out(delayed)
            );
            assign shaped[ch] = half_bridge_in ? delayed : raw[ch];
        end
    endgenerate

    // ------------------------------------------------------------
    // output pin drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pin_level_q <= 4'h0;
            pin_oe_q <= 4'hf;
        end else if (clk_en_in) begin
            if (run_q && !flag_q && !trip_now) begin
                pin_level_q <= shaped;
                pin_oe_q <= 4'hf;
            end else begin
                pin_level_q[0] <= ac_state == pwm_shutdown_pkg::PIN_STATE_HIGH;
                pin_level_q[2] <= ac_state == pwm_shutdown_pkg::PIN_STATE_HIGH;
                pin_oe_q[0] <= !ac_state[1];
                pin_oe_q[2] <= !ac_state[1];
                pin_level_q[1] <= bd_state == pwm_shutdown_pkg::PIN_STATE_HIGH;
                pin_level_q[3] <= bd_state == pwm_shutdown_pkg::PIN_STATE_HIGH;
                pin_oe_q[1] <= !bd_state[1];
                pin_oe_q[3] <= !bd_state[1];
            end
        end
    end

    assign pwm_output_a_out = pin_level_q[0];
    assign pwm_output_b_out = pin_level_q[1];
    assign pwm_output_c_out = pin_level_q[2];
    assign pwm_output_d_out = pin_level_q[3];
    assign pwm_output_a_oe_out = pin_oe_q[0];
    assign pwm_output_b_oe_out = pin_oe_q[1];
    assign pwm_output_c_oe_out = pin_oe_q[2];
    assign pwm_output_d_oe_out = pin_oe_q[3];

endmodule

// ### inc/pwm_shutdown_pkg.sv
/*
 * Constants for the PWM auto-shutdown and dead-band block: register
 * offsets, field positions, reset values, trip source and pin-state codes.
 * Assumes a plain single-clock register port of eight data bits.
 */
package pwm_shutdown_pkg;

    // ----------------
    // register map
    // ----------------
    localparam logic [1:0] ADDR_SHUTDOWN_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_DEADBAND_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_IRQ_STATUS = 2'h2;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;

    // ----------------
    // shutdown control fields
    // ----------------
    localparam int EVENT_FLAG_BIT = 7;
    localparam int SOURCE_MSB = 6;
    localparam int SOURCE_LSB = 4;
    localparam int AC_STATE_MSB = 3;
    localparam int AC_STATE_LSB = 2;
    localparam int BD_STATE_MSB = 1;
    localparam int BD_STATE_LSB = 0;

    // ----------------
    // dead-band control fields
    // ----------------
    localparam int AUTO_RESTART_BIT = 7;
    localparam int DEADBAND_WIDTH = 7;

    // ----------------
    // interrupt status fields
    // ----------------
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_RESTART_BIT = 1;
    localparam int IRQ_WIDTH = 2;

    // ----------------
    // reset values
    // ----------------
    localparam logic [7:0] SHUTDOWN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DEADBAND_CONTROL_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ----------------
    // shutdown pin state codes
    // ----------------
    localparam logic [1:0] PIN_STATE_LOW = 2'h0;
    localparam logic [1:0] PIN_STATE_HIGH = 2'h1;

    // ----------------
    // trip source select codes
    // ----------------
    localparam logic [2:0] SRC_DISABLED = 3'h0;
    localparam logic [2:0] SRC_CMP_ONE = 3'h1;
    localparam logic [2:0] SRC_CMP_TWO = 3'h2;
    localparam logic [2:0] SRC_CMP_EITHER = 3'h3;
    localparam logic [2:0] SRC_PIN = 3'h4;
    localparam logic [2:0] SRC_PIN_CMP_ONE = 3'h5;
    localparam logic [2:0] SRC_PIN_CMP_TWO = 3'h6;
    localparam logic [2:0] SRC_PIN_CMP_EITHER = 3'h7;

    // ----------------
    // timing
    // ----------------
    localparam int OSC_PER_INSTR = 4;

endpackage

// ### src/deadband_delay.sv
/*
 * One dead-band delay channel: a rising edge of the raw PWM level is held
 * back by a programmed number of ticks, a falling edge passes at once.
 * Assumes the tick enable marks one instruction cycle.
 */
`timescale 1ns/1ps

module deadband_delay #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // delay control
    input wire logic tick_in,
    input wire logic [WIDTH-1:0] delay_in,
    // signal
    input wire logic level_in,
    output logic level_out
);

    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("deadband_delay: WIDTH out of range");
        end
    end

    logic [WIDTH-1:0] count_q;
    logic level_q;

    // ----------------
    // delay on inactive-to-active only
    // ----------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            count_q <= '0;
            level_q <= 1'b0;
        end else if (clk_en_in) begin
            if (!level_in) begin
                level_q <= 1'b0;
                count_q <= '0;
            end else if (!level_q) begin
                if (count_q >= delay_in) begin
                    level_q <= 1'b1;
                end else if (tick_in) begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end

    assign level_out = level_q;

endmodule

// ### verif/bridge_model.sv
/* far-side power bridge: resolves the four output pins to gate levels.
   assumes a pull-down on every gate, so a released pin reads low. */
`timescale 1ns/1ps
module bridge_model (
    // pins from the device
    input wire logic [3:0] level_in,
    input wire logic [3:0] oe_in,
    // gate levels and overlap flag
    output logic [3:0] gate_out,
    output logic shoot_out
);
    // ----------------------------------------
    // gate resolution
    // ----------------------------------------
    // released pin pulled low
    assign gate_out = level_in & oe_in;
    // upper and lower switch on together
    assign shoot_out = gate_out[0] & gate_out[1];
endmodule

// ### verif/pwm_shutdown_checker.sv
/* concurrent checks on the ports of the pwm shutdown block.
   assumes clk_en_in is held high. */
`timescale 1ns/1ps
module pwm_shutdown_checker (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // pwm side and trips
    input wire logic pwm_a_in,
    input wire logic half_bridge_in,
    input wire logic period_start_in,
    input wire logic comparator_one_in,
    input wire logic ext_int_pin_in,
    // pins and interrupt
    input wire logic pwm_output_a_out,
    input wire logic pwm_output_a_oe_out,
    input wire logic pwm_output_c_out,
    input wire logic pwm_output_c_oe_out,
    input wire logic pwm_output_b_oe_out,
    input wire logic pwm_output_d_oe_out,
    input wire logic irq_out
);
    // ----------------------------------------
    // shadow of the control fields
    // ----------------------------------------
    logic [6:0] ctrl_q;
    logic [1:0] ac_st;
    logic ac_tri;
    logic bd_tri;
    logic trip_lvl;
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ctrl_q <= 7'h00;
        end else if (reg_write_in && reg_addr_in == pwm_shutdown_pkg::ADDR_SHUTDOWN_CONTROL) begin
            ctrl_q <= reg_wdata_in[6:0];
        end
    end
    assign ac_st = ctrl_q[3:2];
    assign ac_tri = ctrl_q[3];
    assign bd_tri = ctrl_q[1];
    assign trip_lvl = (comparator_one_in && ctrl_q[4]) || (!ext_int_pin_in && ctrl_q[6]);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    AST_RDATA_IDLE: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_FLAG_WHILE_TRIP: assert property (
        trip_lvl [*5] ##0 reg_read_in && reg_addr_in == 2'h0 |=> reg_rdata_out[7])
        else $error("event flag low while trip present");
    AST_SHUTDOWN_PINS: assert property (
        (trip_lvl && ac_st == 2'h1) [*5] |-> pwm_output_a_out && pwm_output_c_out && pwm_output_a_oe_out)
        else $error("pins a and c not driven high in shutdown");
    AST_FALL_PASS: assert property (
        (!pwm_a_in && ac_st != 2'h1) [*3] |-> !pwm_output_a_out || !pwm_output_a_oe_out)
        else $error("falling edge of pin a held back");
    AST_RISE_DELAYED: assert property (
        $rose(pwm_output_a_out) && pwm_output_a_oe_out && $past(pwm_output_a_oe_out) && half_bridge_in
        && $past(half_bridge_in, 2) && ac_st != 2'h1 && $past(ac_st) != 2'h1
        |-> $past(pwm_a_in) && $past(pwm_a_in, 2))
        else $error("rising edge of pin a not delayed");
    AST_AC_TRISTATE: assert property (
        !pwm_output_a_oe_out || !pwm_output_c_oe_out |-> $past(ac_tri) && pwm_output_a_oe_out == pwm_output_c_oe_out)
        else $error("pins a and c released without float state");
    AST_BD_TRISTATE: assert property (
        !pwm_output_b_oe_out || !pwm_output_d_oe_out |-> $past(bd_tri) && pwm_output_b_oe_out == pwm_output_d_oe_out)
        else $error("pins b and d released without float state");
    AST_IRQ_MASKED: assert property (reg_write_in && reg_addr_in == 2'h3 && reg_wdata_in[1:0] == 2'h0 |=> !irq_out)
        else $error("interrupt high with all events masked");
    AST_IRQ_CLEAR: assert property (
        reg_write_in && reg_addr_in == 2'h2 && reg_wdata_in[1:0] == 2'h3 && !period_start_in |=> !irq_out)
        else $error("interrupt high after clearing all events");
    AST_IRQ_STICKY: assert property (irq_out && !reg_write_in |=> irq_out)
        else $error("interrupt dropped without a write");

    cover property (trip_lvl [*5]);
    cover property ($rose(irq_out));
    cover property (half_bridge_in && $rose(pwm_output_a_out));
endmodule

bind pwm_auto_shutdown_deadband pwm_shutdown_checker chk (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .pwm_a_in(pwm_a_in), .half_bridge_in(half_bridge_in),
    .period_start_in(period_start_in), .comparator_one_in(comparator_one_in),
    .ext_int_pin_in(ext_int_pin_in), .pwm_output_a_out(pwm_output_a_out),
    .pwm_output_a_oe_out(pwm_output_a_oe_out), .pwm_output_c_out(pwm_output_c_out),
    .pwm_output_c_oe_out(pwm_output_c_oe_out), .pwm_output_b_oe_out(pwm_output_b_oe_out),
    .pwm_output_d_oe_out(pwm_output_d_oe_out), .irq_out(irq_out)
);

// ### verif/tb.sv
/* directed bench for the pwm shutdown block over its register port.
   assumes the bridge model pulls released pins low. */
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0, rd_s = 1'b0, per_s = 1'b0, hb = 1'b0, tick = 1'b0;
    logic c1 = 1'b0, c2 = 1'b0, pin = 1'b1, sync_en = 1'b0, t1s = 1'b0;
    logic [1:0] tdiv = 2'h0;
    logic [3:0] raw = 4'ha;
    logic [7:0] rdata, v;
    logic [3:0] lvl, oe, wires;
    logic shoot, irq;
    logic shot = 1'b0;
    int miscompares = 0, n_compared = 0;
    int na, nb, lo, hi;
    int dtab[4] = '{127, 3, 0, 3};

    pwm_auto_shutdown_deadband dut (
        .sys_clk_in(clk), .resetn_in(resetn), .clk_en_in(1'b1),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
        .reg_rdata_out(rdata), .pwm_a_in(raw[0]), .pwm_b_in(raw[1]), .pwm_c_in(raw[2]),
        .pwm_d_in(raw[3]), .period_start_in(per_s), .half_bridge_in(hb), .instr_tick_in(tick),
        .comparator_one_in(c1), .comparator_two_in(c2), .ext_int_pin_in(pin),
        .comparator_two_sync_enable_in(sync_en), .timer_one_sync_in(t1s),
        .pwm_output_a_out(lvl[0]), .pwm_output_a_oe_out(oe[0]), .pwm_output_b_out(lvl[1]),
        .pwm_output_b_oe_out(oe[1]), .pwm_output_c_out(lvl[2]), .pwm_output_c_oe_out(oe[2]),
        .pwm_output_d_out(lvl[3]), .pwm_output_d_oe_out(oe[3]), .irq_out(irq)
    );
    bridge_model bridge (.level_in(lvl), .oe_in(oe), .gate_out(wires), .shoot_out(shoot));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int l, input int h, input int got);
        n_compared++;
        if (got < l || got > h) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, l, h, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk_v(what, exp, rdata);
    endtask
    task automatic see(input string what, input logic [7:0] exp);
        @(negedge clk);
        chk_v(what, exp, {oe, wires});
    endtask
    task automatic period();
        @(posedge clk);
        per_s <= 1'b1;
        @(posedge clk);
        per_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic recover(input logic [7:0] ctrl, input logic [7:0] hold);
        @(posedge clk);
        sync_en <= 1'b0;
        c1 <= 1'b0;
        c2 <= 1'b0;
        pin <= 1'b1;
        cyc(5);
        wr(2'h0, ctrl);
        see("held pins", hold);
        period();
        see("resumed pins", 8'hfa);
    endtask
    task automatic edges(input logic [3:0] nr);
        @(posedge clk);
        raw <= nr;
        na = 0;
        nb = 0;
        for (int i = 1; i <= 600; i++) begin
            @(negedge clk);
            if (na == 0 && wires[0] === nr[0]) na = i;
            if (nb == 0 && wires[1] === nr[1]) nb = i;
            if (shoot !== 1'b0) shot = 1'b1;
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, tick and watchdog
    // ----------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        results();
    end

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdc(i[1:0], 8'h00, "reset value");
        end
        see("run pins", 8'hfa);
        // every source code against every trip kind
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 3; k++) begin
                v = {1'b0, s[2:0], 4'h4};
                wr(2'h0, v);
                c1 <= (k == 0);
                c2 <= (k == 1);
                pin <= (k != 2);
                cyc(5);
                see("trip pins", s[k] ? 8'hf5 : 8'hfa);
                wr(2'h0, v);
                rdc(2'h0, {s[k], v[6:0]}, "event flag");
                recover(v, s[k] ? 8'hf5 : 8'hfa);
            end
        end
        // shutdown pin states
        for (int st = 0; st < 4; st++) begin
            v = {4'h1, st[1:0], st[1:0]};
            wr(2'h0, v);
            c1 <= 1'b1;
            cyc(5);
            see("pin states", {{4{~st[1]}}, {4{st[0] & ~st[1]}}});
            recover(v, {{4{~st[1]}}, {4{st[0] & ~st[1]}}});
        end
        // interrupt status, mask and clear
        rdc(2'h2, 8'h03, "irq status");
        chk_v("irq masked", 8'h00, {7'h0, irq});
        wr(2'h3, 8'h03);
        rdc(2'h3, 8'h03, "irq mask");
        chk_v("irq high", 8'h01, {7'h0, irq});
        wr(2'h2, 8'h00);
        rdc(2'h2, 8'h03, "irq zero write");
        wr(2'h2, 8'h01);
        rdc(2'h2, 8'h02, "irq clear one");
        wr(2'h2, 8'h03);
        rdc(2'h2, 8'h00, "irq clear all");
        chk_v("irq low", 8'h00, {7'h0, irq});
        wr(2'h3, 8'h01);
        wr(2'h0, 8'h14);
        c1 <= 1'b1;
        cyc(5);
        rdc(2'h2, 8'h01, "irq trip onset");
        chk_v("irq trip", 8'h01, {7'h0, irq});
        recover(8'h14, 8'hf5);
        wr(2'h2, 8'h01);
        rdc(2'h2, 8'h02, "irq restart");
        chk_v("irq restart masked", 8'h00, {7'h0, irq});
        wr(2'h3, 8'h00);
        // automatic restart
        wr(2'h1, 8'h80);
        c1 <= 1'b1;
        cyc(5);
        rdc(2'h0, 8'h94, "auto flag set");
        @(posedge clk) c1 <= 1'b0;
        cyc(5);
        rdc(2'h0, 8'h14, "auto flag clear");
        see("auto held", 8'hf5);
        period();
        see("auto resumed", 8'hfa);
        // comparator two through the timer sync point
        wr(2'h1, 8'h00);
        sync_en <= 1'b1;
        wr(2'h0, 8'h24);
        c2 <= 1'b1;
        cyc(6);
        rdc(2'h0, 8'h24, "sync held off");
        @(posedge clk);
        t1s <= 1'b1;
        @(posedge clk);
        t1s <= 1'b0;
        cyc(5);
        rdc(2'h0, 8'ha4, "sync trip");
        recover(8'h24, 8'hf5);
        // dead-band on rising edges, falling edges pass undelayed
        wr(2'h0, 8'h00);
        for (int j = 0; j < 4; j++) begin
            wr(2'h1, {1'b0, dtab[j][6:0]});
            hb <= (j < 3);
            lo = (j < 3) ? ((dtab[j] > 0) ? (dtab[j] - 1) * 4 + 1 : 1) : 1;
            hi = (j < 3) ? dtab[j] * 4 + 4 : 3;
            edges(4'h5);
            chk_rng("rise a", lo, hi, na);
            chk_rng("fall b", 1, 3, nb);
            edges(4'ha);
            chk_rng("rise b", lo, hi, nb);
            chk_rng("fall a", 1, 3, na);
        end
        chk_v("shoot-through", 8'h00, {7'h0, shot});
        results();
    end
endmodule
